// [logic/cts_params.svh]
// Purpose: Constants for the current-transformer wiring supervision block
// Assumes: APB byte addresses, 32-bit data, currents in 0.01 x In units
// Notes: Ratios in 0.01 % units, alarm delay in 5 ms steps
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH

`define CTS_PCLK_NS 4
`define CTS_STEP_TIME_NS 5000000
`define CTS_PCT_FULL 16'h2710
`define CTS_LOG_DEPTH 12
`define CTS_LOG_LAST 4'hB

`define CTS_A_CTRL 8'h00
`define CTS_A_UPPER 8'h04
`define CTS_A_LOWER 8'h08
`define CTS_A_IMBAL 8'h0C
`define CTS_A_SEQ 8'h10
`define CTS_A_RESLIM 8'h14
`define CTS_A_DELAY 8'h18
`define CTS_A_EVSEL 8'h1C
`define CTS_A_STATE 8'h20
`define CTS_A_TTA 8'h24
`define CTS_A_COUNTS 8'h28
`define CTS_A_IRQ_STAT 8'h2C
`define CTS_A_IRQ_MASK 8'h30
`define CTS_A_LOG_SEL 8'h34
`define CTS_A_LOG_BASE 8'h40
`define CTS_A_LOG_END 8'h58

`define CTS_B_RES_SEL 1
`define CTS_B_CNT_CLR 2

`define CTS_R_UPPER 16'h0078
`define CTS_R_LOWER 16'h000A
`define CTS_R_IMBAL 16'h03E8
`define CTS_R_SEQ 16'h1324
`define CTS_R_RESLIM 16'h000A
`define CTS_R_DELAY 19'h00064
`define CTS_R_EVSEL 4'hF

`endif

// [logic/cts_pkg.sv]
// Purpose: Types for the current-transformer wiring supervision block
// Assumes: Currents are 16-bit magnitudes in 0.01 x In units
// Notes: Log record is packed to exactly seven 32-bit words
package cts_pkg;

  typedef struct packed {
    logic [15:0] il1;
    logic [15:0] il2;
    logic [15:0] il3;
    logic [15:0] i0_meas;
    logic [15:0] i0_diff;
    logic [15:0] i_pos;
    logic [15:0] i_neg;
  } meas_t;

  typedef struct packed {
    logic block_off;
    logic block_on;
    logic alarm_off;
    logic alarm_on;
  } evt_t;

  typedef struct packed {
    logic [33:0] pad;
    logic [47:0] stamp_ms;
    logic [1:0] event_code;
    logic [2:0] group;
    logic [5:0] fault_code;
    logic [18:0] time_to_alarm;
    meas_t currents;
  } log_rec_t;

  typedef enum logic [1:0] {
    EV_ALARM_ON,
    EV_BLOCK_ON,
    EV_ALARM_OFF,
    EV_BLOCK_OFF
  } event_code_t;

  typedef enum {
    ST_IDLE,
    ST_TIMING,
    ST_ALARM,
    ST_BLOCKED
  } sup_state_t;

endpackage

// [logic/ct_wiring_supervision.sv]
// Purpose: Current-transformer wiring supervision with alarm timer, events and log
// Assumes: Measurements valid when cycle_start pulses; APB slave, zero wait states
// Notes: Alarm delay counted in 5 ms steps of pclk
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`include "cts_params.svh"

module ct_wiring_supervision #(
  parameter int STEP_CYCLES = `CTS_STEP_TIME_NS / `CTS_PCLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycle_start,
  input wire cts_pkg::meas_t meas,
  input wire logic block_in,
  input wire logic [47:0] now_ms,
  input wire logic [2:0] setting_group,
  output logic alarm,
  output logic blocked,
  output logic event_valid,
  output cts_pkg::evt_t event_flags,
  output logic [47:0] event_stamp_ms,
  output logic irq
);

  // ------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] scale(input logic [15:0] v, input logic [15:0] k);
    scale = {16'h0000, v} * {16'h0000, k};
  endfunction

  function automatic logic [15:0] max3(input logic [15:0] a, b, c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction

  function automatic logic [15:0] min3(input logic [15:0] a, b, c);
    logic [15:0] m;
    m = (a < b) ? a : b;
    min3 = (m < c) ? m : c;
  endfunction

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic res_sel;
  logic [15:0] upper_phase_limit;
  logic [15:0] lower_phase_limit;
  logic [15:0] imbalance_limit;
  logic [15:0] sequence_ratio_limit;
  logic [15:0] residual_limit;
  logic [18:0] alarm_delay;
  cts_pkg::evt_t ev_select;
  cts_pkg::evt_t irq_status;
  cts_pkg::evt_t irq_mask;
  logic [3:0] log_sel;
  logic [3:0] log_wr;
  logic [3:0] log_fill;
  logic [15:0] alarm_count;
  logic [15:0] block_count;
  cts_pkg::sup_state_t state;
  cts_pkg::sup_state_t next_state;
  cts_pkg::meas_t held;
  logic [5:0] held_fault;
  logic blk_sampled;
  logic [31:0] presc;
  logic [18:0] steps;
  cts_pkg::log_rec_t log_mem [0:`CTS_LOG_DEPTH-1];

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire acc = psel & penable & clk_en;
  wire wr = acc & pwrite;
  wire w_ctrl = wr & (paddr == `CTS_A_CTRL);
  wire w_upper = wr & (paddr == `CTS_A_UPPER);
  wire w_lower = wr & (paddr == `CTS_A_LOWER);
  wire w_imbal = wr & (paddr == `CTS_A_IMBAL);
  wire w_seq = wr & (paddr == `CTS_A_SEQ);
  wire w_reslim = wr & (paddr == `CTS_A_RESLIM);
  wire w_delay = wr & (paddr == `CTS_A_DELAY);
  wire w_evsel = wr & (paddr == `CTS_A_EVSEL);
  wire w_istat = wr & (paddr == `CTS_A_IRQ_STAT);
  wire w_imask = wr & (paddr == `CTS_A_IRQ_MASK);
  wire w_logsel = wr & (paddr == `CTS_A_LOG_SEL);
  wire cnt_clr = w_ctrl & pwdata[`CTS_B_CNT_CLR];
  wire log_hit = (paddr >= `CTS_A_LOG_BASE) && (paddr <= `CTS_A_LOG_END)
    && (paddr[1:0] == 2'b00);
  wire [7:0] log_off = paddr - `CTS_A_LOG_BASE;
  wire [2:0] log_word = log_off[4:2];
  wire [223:0] log_flat = log_mem[log_sel];
  wire log_sel_ok = log_sel <= `CTS_LOG_LAST;

  // ------------------------------------------------------------
  // Pick-up conditions
  // ------------------------------------------------------------
  wire [15:0] i_max = max3(meas.il1, meas.il2, meas.il3);
  wire [15:0] i_min = min3(meas.il1, meas.il2, meas.il3);
  wire high_ok = i_max <= upper_phase_limit;
  // at least one phase at or above lower limit
  wire low_ok = i_max >= lower_phase_limit;
  wire imbal_ok = scale(i_min, `CTS_PCT_FULL) <= scale(i_max, imbalance_limit);
  wire seq_ok = scale(meas.i_neg, `CTS_PCT_FULL) >= scale(meas.i_pos, sequence_ratio_limit);
  wire res_ok = !res_sel
    || ((meas.i0_diff != 16'h0000) && (meas.i0_diff >= residual_limit));
  wire pickup = high_ok & low_ok & imbal_ok & seq_ok & res_ok;
  wire [5:0] fault_now = {block_in, res_ok, seq_ok, imbal_ok, low_ok, high_ok};

  // ------------------------------------------------------------
  // Supervision state machine
  // ------------------------------------------------------------
  // step timer expiry
  wire step_wrap = presc == 32'(STEP_CYCLES - 1);
  wire expired = steps >= alarm_delay;

  always_comb begin
    next_state = state;
    if (cycle_start) begin
      if (!pickup) begin
        next_state = cts_pkg::ST_IDLE;
      end else if (block_in) begin
        next_state = cts_pkg::ST_BLOCKED;
      end else if (state == cts_pkg::ST_IDLE || state == cts_pkg::ST_BLOCKED) begin
        next_state = cts_pkg::ST_TIMING;
      end
    end else if (state == cts_pkg::ST_TIMING && expired) begin
      next_state = cts_pkg::ST_ALARM;
    end
  end

  wire was_alarm = state == cts_pkg::ST_ALARM;
  wire is_alarm = next_state == cts_pkg::ST_ALARM;
  wire was_blk = state == cts_pkg::ST_BLOCKED;
  wire is_blk = next_state == cts_pkg::ST_BLOCKED;
  wire cts_pkg::evt_t ev_now = '{
    block_off: was_blk & !is_blk,
    block_on: !was_blk & is_blk,
    alarm_off: was_alarm & !is_alarm,
    alarm_on: !was_alarm & is_alarm
  };
  wire cts_pkg::evt_t ev_kept = ev_now & ev_select;
  wire log_now = ev_now.alarm_on | ev_now.block_on;
  wire [18:0] tta = expired ? 19'h00000 : alarm_delay - steps;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cts_pkg::ST_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Timer restarts on every entry to timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 32'h0000_0000;
      steps <= 19'h00000;
    end else if (clk_en) begin
      if (next_state != cts_pkg::ST_TIMING || state != cts_pkg::ST_TIMING) begin
        presc <= 32'h0000_0000;
        steps <= 19'h00000;
      end else if (step_wrap) begin
        presc <= 32'h0000_0000;
        steps <= steps + 19'h00001;
      end else begin
        presc <= presc + 32'h0000_0001;
      end
    end
  end

  // Trigger currents held from last program cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= '0;
      held_fault <= 6'h00;
      blk_sampled <= 1'b0;
    end else if (clk_en && cycle_start) begin
      held <= meas;
      held_fault <= fault_now;
      blk_sampled <= block_in;
    end
  end

  // ------------------------------------------------------------
  // Outputs, events and counters
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm <= 1'b0;
      blocked <= 1'b0;
      event_valid <= 1'b0;
      event_flags <= '0;
      event_stamp_ms <= 48'h0000_0000_0000;
    end else if (clk_en) begin
      alarm <= is_alarm;
      blocked <= is_blk;
      event_valid <= |ev_kept;
      event_flags <= ev_kept;
      if (|ev_kept) begin
        event_stamp_ms <= now_ms;
      end
    end
  end

  // Increment beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_count <= 16'h0000;
      block_count <= 16'h0000;
    end else if (clk_en) begin
      alarm_count <= (cnt_clr ? 16'h0000 : alarm_count) + {15'h0000, ev_now.alarm_on};
      block_count <= (cnt_clr ? 16'h0000 : block_count) + {15'h0000, ev_now.block_on};
    end
  end

  // ------------------------------------------------------------
  // Operation log
  // ------------------------------------------------------------
  // record contents
  wire cts_pkg::log_rec_t rec_now = '{
    pad: '0,
    stamp_ms: now_ms,
    event_code: ev_now.alarm_on ? cts_pkg::EV_ALARM_ON : cts_pkg::EV_BLOCK_ON,
    group: setting_group,
    fault_code: cycle_start ? fault_now : held_fault,
    time_to_alarm: tta,
    currents: cycle_start ? meas : held
  };

  // Memory has no reset; the fill count guards reads
  always_ff @(posedge pclk) begin
    if (clk_en && log_now) begin
      log_mem[log_wr] <= rec_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_wr <= 4'h0;
      log_fill <= 4'h0;
    end else if (clk_en && log_now) begin
      log_wr <= (log_wr == `CTS_LOG_LAST) ? 4'h0 : log_wr + 4'h1;
      if (log_fill != `CTS_LOG_LAST + 4'h1) begin
        log_fill <= log_fill + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_sel <= 1'b0;
      upper_phase_limit <= `CTS_R_UPPER;
      lower_phase_limit <= `CTS_R_LOWER;
      imbalance_limit <= `CTS_R_IMBAL;
      sequence_ratio_limit <= `CTS_R_SEQ;
      residual_limit <= `CTS_R_RESLIM;
      alarm_delay <= `CTS_R_DELAY;
      ev_select <= `CTS_R_EVSEL;
      irq_mask <= '0;
      log_sel <= 4'h0;
    end else if (clk_en) begin
      if (w_ctrl) res_sel <= pwdata[`CTS_B_RES_SEL];
      if (w_upper) upper_phase_limit <= pwdata[15:0];
      if (w_lower) lower_phase_limit <= pwdata[15:0];
      if (w_imbal) imbalance_limit <= pwdata[15:0];
      if (w_seq) sequence_ratio_limit <= pwdata[15:0];
      if (w_reslim) residual_limit <= pwdata[15:0];
      if (w_delay) alarm_delay <= pwdata[18:0];
      if (w_evsel) ev_select <= pwdata[3:0];
      if (w_imask) irq_mask <= pwdata[3:0];
      if (w_logsel) log_sel <= pwdata[3:0];
    end
  end

  // Event set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~(w_istat ? pwdata[3:0] : 4'h0)) | ev_now;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  wire [31:0] state_word = {24'h000000, blk_sampled, held_fault[4:0],
    blocked, alarm};

  assign pready = clk_en;

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `CTS_A_CTRL: prdata = {30'h0000_0000, res_sel, 1'b0};
      `CTS_A_UPPER: prdata = {16'h0000, upper_phase_limit};
      `CTS_A_LOWER: prdata = {16'h0000, lower_phase_limit};
      `CTS_A_IMBAL: prdata = {16'h0000, imbalance_limit};
      `CTS_A_SEQ: prdata = {16'h0000, sequence_ratio_limit};
      `CTS_A_RESLIM: prdata = {16'h0000, residual_limit};
      `CTS_A_DELAY: prdata = {13'h0000, alarm_delay};
      `CTS_A_EVSEL: prdata = {28'h000_0000, ev_select};
      `CTS_A_STATE: prdata = state_word;
      `CTS_A_TTA: prdata = {13'h0000, tta};
      `CTS_A_COUNTS: prdata = {block_count, alarm_count};
      `CTS_A_IRQ_STAT: prdata = {28'h000_0000, irq_status};
      `CTS_A_IRQ_MASK: prdata = {28'h000_0000, irq_mask};
      `CTS_A_LOG_SEL: prdata = {20'h00000, log_fill, log_wr, log_sel};
      default: begin
        if (log_hit) begin
          // Slots beyond the fill count read as zero
          prdata = (log_sel_ok && log_sel < log_fill) ? log_flat[log_word*32 +: 32]
            : 32'h0000_0000;
        end else begin
          pslverr = acc;
        end
      end
    endcase
  end

endmodule

// [tb/cts_checker.sv]
// Purpose: Port-level checks for the wiring supervision block
// Assumes: Single pclk domain, clk_en held high by the bench
// Notes: Limits live in registers, so checks tie outputs to timing only
`timescale 1ns/1ns
module cts_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cycle_start,
  input wire logic block_in,
  input wire logic [47:0] now_ms,
  input wire logic alarm,
  input wire logic blocked,
  input wire logic event_valid,
  input wire cts_pkg::evt_t event_flags,
  input wire logic [47:0] event_stamp_ms
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_alarm_up;
    $rose(alarm);
  endsequence
  sequence s_alarm_report;
    event_valid && event_flags.alarm_on;
  endsequence
  property p_blk_cause;
    $rose(blocked) |-> $past(cycle_start) && $past(block_in);
  endproperty
  property p_blk_hold;
    blocked && !cycle_start |=> blocked;
  endproperty
  property p_alarm_hold;
    alarm && !cycle_start |=> alarm;
  endproperty
  property p_alarm_fall;
    $fell(alarm) |-> $past(cycle_start);
  endproperty
  property p_excl;
    alarm |-> !blocked;
  endproperty
  property p_stamp;
    event_valid |-> event_stamp_ms == $past(now_ms);
  endproperty
  property p_evt_cause;
    event_valid |-> $past(cycle_start) || $rose(alarm);
  endproperty
  property p_alarm_evt;
    s_alarm_up |-> s_alarm_report;
  endproperty
  a_blk_cause: assert property (p_blk_cause) else $error("blocked without block");
  a_blk_hold: assert property (p_blk_hold) else $error("blocked left early");
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm left early");
  a_alarm_fall: assert property (p_alarm_fall) else $error("alarm fell off cycle");
  a_excl: assert property (p_excl) else $error("alarm and blocked");
  a_stamp: assert property (p_stamp) else $error("bad event stamp");
  a_evt_cause: assert property (p_evt_cause) else $error("stray event");
  a_alarm_evt: assert property (p_alarm_evt) else $error("alarm without event");
endmodule
bind ct_wiring_supervision cts_checker u_chk (.pclk(pclk), .presetn(presetn),
  .cycle_start(cycle_start), .block_in(block_in), .now_ms(now_ms), .alarm(alarm),
  .blocked(blocked), .event_valid(event_valid), .event_flags(event_flags),
  .event_stamp_ms(event_stamp_ms));

// [tb/cts_front_end.sv]
// Purpose: Measurement front end model
// Assumes: One request pulse per program cycle
// Notes: Lines carry inverted data outside the strobe
`timescale 1ns/1ns
module cts_front_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire cts_pkg::meas_t req_meas,
  input wire logic req_block,
  output logic cycle_start,
  output cts_pkg::meas_t meas,
  output logic block_in,
  output logic [47:0] now_ms
);
  cts_pkg::meas_t held;
  logic held_block;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_start <= 1'b0;
      held <= '0;
      held_block <= 1'b0;
      now_ms <= 48'h0;
    end else begin
      cycle_start <= req;
      now_ms <= now_ms + 48'h1;
      if (req) begin
        held <= req_meas;
        held_block <= req_block;
      end
    end
  end
  // Not valid between strobes
  assign meas = cycle_start ? held : ~held;
  assign block_in = cycle_start ? held_block : ~held_block;
endmodule

// [tb/ct_wiring_supervision_test.sv]
// Purpose: Self-checking bench for the wiring supervision block
// Assumes: STEP_CYCLES of 4 to keep alarm delays short
// Notes: APB master tasks, front end model drives measurements
`timescale 1ns/1ns
module ct_wiring_supervision_test;
  logic pclk, presetn, psel, penable, pwrite, req, req_block, err;
  logic pready, pslverr, cycle_start, block_in, alarm, blocked, event_valid, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [47:0] now_ms, event_stamp_ms;
  logic [31:0] ctl [5];
  cts_pkg::meas_t meas, req_meas, flt, ok;
  cts_pkg::meas_t mm [5];
  cts_pkg::evt_t event_flags, last_ev;
  int fails, n_checks, cyc, ev_n, n0;
  ct_wiring_supervision #(.STEP_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cycle_start(cycle_start), .meas(meas), .block_in(block_in), .now_ms(now_ms),
    .setting_group(3'h2), .alarm(alarm), .blocked(blocked), .event_valid(event_valid),
    .event_flags(event_flags), .event_stamp_ms(event_stamp_ms), .irq(irq));
  cts_front_end u_fe (.pclk(pclk), .presetn(presetn), .req(req), .req_meas(req_meas),
    .req_block(req_block), .cycle_start(cycle_start), .meas(meas), .block_in(block_in),
    .now_ms(now_ms));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic go(input cts_pkg::meas_t m, input logic b);
    req <= 1'b1;
    req_meas <= m;
    req_block <= b;
    @(posedge pclk);
    req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic wait_alarm;
    for (int i = 0; i < 40 && alarm !== 1'b1; i++) @(posedge pclk);
    // One more edge so the event monitor has logged the alarm pulse
    @(posedge pclk);
  endtask
  function automatic cts_pkg::meas_t mk(input logic [15:0] a, b, c, d, p, n);
    mk = '{a, b, c, 16'h0000, d, p, n};
  endfunction
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard, well above the expected run
  always @(posedge pclk) begin
    cyc++;
    if (event_valid === 1'b1) begin
      ev_n++;
      last_ev = event_flags;
    end
    if (cyc == 8000) begin
      fails++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, req, req_block} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_meas = '0;
    last_ev = '0;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    ev_n = 0;
    flt = mk(16'h0000, 16'h0064, 16'h0064, 16'h0014, 16'h0043, 16'h0021);
    ok = mk(16'h0064, 16'h0064, 16'h0064, 16'h0000, 16'h0064, 16'h0000);
    mm = '{mk(16'h0, 16'h0082, 16'h0064, 16'h0014, 16'h0043, 16'h0021),
      mk(16'h0, 16'h0009, 16'h0009, 16'h0014, 16'h0006, 16'h0003),
      mk(16'h0, 16'h0064, 16'h0064, 16'h0014, 16'h0043, 16'h000A),
      mk(16'h0, 16'h0064, 16'h0064, 16'h0000, 16'h0043, 16'h0021),
      mk(16'h0, 16'h0064, 16'h0064, 16'h0005, 16'h0043, 16'h0021)};
    ctl = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h2};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h04, 32'h00000078);
    rd(8'h18, 32'h00000064);
    rd(8'h1C, 32'h0000000F);
    rd(8'h30, 32'h00000000);
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h30, 32'h1);
    go(flt, 1'b0);
    wait_alarm();
    chk({31'h0, alarm}, 32'h1);
    chk({28'h0, last_ev}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(8'h28, 32'h00000001);
    rd(8'h34, 32'h00000110);
    rd(8'h40, 32'h00430021);
    rd(8'h44, 32'h00000014);
    rd(8'h48, 32'h00640064);
    rd(8'h4C, 32'h00000000);
    apb(1'b0, 8'h50, 32'h0);
    chk(q & 32'h0000_3FFF, 32'h000004F8);
    apb(1'b1, 8'h2C, 32'h1);
    chk({31'h0, irq}, 32'h0);
    go(ok, 1'b0);
    chk({31'h0, alarm}, 32'h0);
    chk({28'h0, last_ev}, 32'h2);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, ctl[i]);
      go(mm[i], 1'b0);
      repeat (20) @(posedge pclk);
      chk({30'h0, alarm, blocked}, 32'h0);
    end
    go(flt, 1'b0);
    wait_alarm();
    chk({31'h0, alarm}, 32'h1);
    go(ok, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    go(flt, 1'b0);
    repeat (4) @(posedge pclk);
    go(ok, 1'b0);
    repeat (20) @(posedge pclk);
    chk({31'h0, alarm}, 32'h0);
    go(flt, 1'b0);
    go(flt, 1'b1);
    repeat (20) @(posedge pclk);
    chk({30'h0, alarm, blocked}, 32'h1);
    chk({28'h0, last_ev}, 32'h4);
    rd(8'h20, 32'h000000FE);
    rd(8'h28, 32'h00010002);
    go(ok, 1'b0);
    chk({31'h0, blocked}, 32'h0);
    chk({28'h0, last_ev}, 32'h8);
    apb(1'b1, 8'h1C, 32'h1);
    go(flt, 1'b0);
    wait_alarm();
    n0 = ev_n;
    go(ok, 1'b0);
    chk(ev_n - n0, 32'h0);
    apb(1'b1, 8'h1C, 32'hF);
    apb(1'b1, 8'h30, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h30, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h00, 32'h4);
    rd(8'h28, 32'h00000000);
    for (int i = 0; i < 12; i++) begin
      go(flt, 1'b1);
      go(ok, 1'b0);
    end
    rd(8'h34, 32'h00000C40);
    rd(8'h28, 32'h000C0000);
    give_verdict();
  end
endmodule
